// File: rtl/pxg_pkg.sv
/*
 Package for the port I/O crossbar and general purpose port block.
 Holds register addresses, reset values, field positions, crossbar
 signal ordering and the packed carriers shared by the design.
 Assumes an 8-bit special function register space on the processor side.
*/
package pxg_pkg;

    // Register addresses in the special function register space
    localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
    localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;
    localparam logic [7:0] ADDR_PORT2_DATA = 8'hA0;
    localparam logic [7:0] ADDR_PORT0_OUTPUT_DRIVE = 8'hA4;
    localparam logic [7:0] ADDR_PORT1_OUTPUT_DRIVE = 8'hA5;
    localparam logic [7:0] ADDR_PORT2_OUTPUT_DRIVE = 8'hA6;
    localparam logic [7:0] ADDR_PORT0_CROSSBAR_BYPASS = 8'hD4;
    localparam logic [7:0] ADDR_PORT1_CROSSBAR_BYPASS = 8'hD5;
    localparam logic [7:0] ADDR_CROSSBAR_CONTROL_B = 8'hE2;
    localparam logic [7:0] ADDR_PORT0_INPUT_KIND = 8'hF1;
    localparam logic [7:0] ADDR_PORT1_INPUT_KIND = 8'hF2;

    // Reset values
    localparam logic [7:0] RST_PORT0_DATA = 8'hFF;
    localparam logic [7:0] RST_PORT1_DATA = 8'hFF;
    localparam logic RST_PORT2_DATA = 1'h1;
    localparam logic [7:0] RST_OUTPUT_DRIVE = 8'h00;
    localparam logic RST_PORT2_OUTPUT_DRIVE = 1'h0;
    localparam logic [7:0] RST_CROSSBAR_BYPASS = 8'h00;
    localparam logic [7:0] RST_CROSSBAR_CONTROL_B = 8'h00;
    localparam logic [7:0] RST_INPUT_KIND = 8'hFF;

    // Crossbar control register B field positions
    localparam int POS_PULLUP_DISABLE = 7;
    localparam int POS_CROSSBAR_ENABLE = 6;
    localparam int POS_TIMER1_ROUTE = 5;
    localparam int POS_TIMER0_ROUTE = 4;
    localparam int POS_COUNTER_CLOCK_ROUTE = 3;
    localparam int POS_CAPTURE_ROUTE = 0;

    // Pin count: port 0, port 1, then the single port 2 pin
    localparam int NUM_PINS = 17;
    localparam int NUM_SIGS = 8;

    // Crossbar signal priority, lowest index taken first
    localparam int SIG_SDA = 0;
    localparam int SIG_SCL = 1;
    localparam int SIG_CAPTURE0 = 2;
    localparam int SIG_CAPTURE1 = 3;
    localparam int SIG_CAPTURE2 = 4;
    localparam int SIG_COUNTER_CLOCK = 5;
    localparam int SIG_T0 = 6;
    localparam int SIG_T1 = 7;

    // Capture output routing codes
    localparam logic [1:0] CAP_NONE = 2'h0;
    localparam logic [1:0] CAP_0 = 2'h1;
    localparam logic [1:0] CAP_01 = 2'h2;

    typedef struct packed {
        logic pullup_disable;
        logic crossbar_enable;
        logic timer1_input_route;
        logic timer0_input_route;
        logic counter_clock_input_route;
        logic unused_bit;
        logic [1:0] capture_output_route;
    } pxg_xbar_ctrl_t;

    // Outputs that on-chip peripherals present to the crossbar
    typedef struct packed {
        logic sda;
        logic scl;
        logic [2:0] capture_out;
    } pxg_periph_drive_t;

    // Pin levels handed back to on-chip peripherals
    typedef struct packed {
        logic sda;
        logic scl;
        logic counter_array_clock_input;
        logic timer0_input;
        logic timer1_input;
    } pxg_periph_sense_t;

endpackage

// File: rtl/pxg_port_io.sv
/*
 Port I/O crossbar with three general purpose ports: data latches,
 pin reads, input kind, output drive, crossbar bypass and routing of
 timer inputs, counter array clock input and capture outputs.
 Assumes the processor issues one register access per cycle and pins
 are already synchronous to clk_sys_in. Open-drain resolution of the
 pads (out, oe, pull-up) is done outside.
*/
`timescale 1ns/100ps

module pxg_port_io (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Special function register access
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_bit_wr_in,
    input wire logic [2:0] sfr_bit_idx_in,
    input wire logic sfr_bit_val_in,
    input wire logic sfr_rd_in,
    input wire logic sfr_rmw_in,
    output logic [7:0] sfr_rdata_out,
    // On-chip peripherals
    input wire logic smbus_route_in,
    input wire pxg_pkg::pxg_periph_drive_t periph_drive_in,
    output pxg_pkg::pxg_periph_sense_t periph_sense_out,
    // Pins: index 0-7 port 0, 8-15 port 1, 16 port 2 bit 0
    input wire logic [16:0] pin_in,
    output logic [16:0] pin_out,
    output logic [16:0] pin_oe_out,
    output logic [16:0] pin_pullup_out,
    output logic [16:0] pin_analog_out
);

    pxg_pkg::pxg_xbar_ctrl_t xbar_reg;
    logic [7:0] port0_latch_reg;
    logic [7:0] port1_latch_reg;
    logic port2_latch_reg;
    logic [7:0] port0_drive_reg;
    logic [7:0] port1_drive_reg;
    logic port2_drive_reg;
    logic [7:0] port0_bypass_reg;
    logic [7:0] port1_bypass_reg;
    logic [7:0] port0_kind_reg;
    logic [7:0] port1_kind_reg;

    logic [16:0] latch_all;
    logic [16:0] drive_all;
    logic [16:0] bypass_all;
    logic [16:0] digital_all;
    logic [7:0] sig_enable;
    logic [7:0] sig_value;
    logic [7:0] sig_is_input;
    logic [16:0] claimed;
    logic [2:0] claim_sig [17];
    logic [7:0] sig_pin_valid;
    logic [4:0] sig_pin [8];
    logic [16:0] pin_out_next;
    logic [16:0] pin_oe_next;
    logic [16:0] pin_pullup_next;
    logic [7:0] rdata_next;
    pxg_pkg::pxg_periph_sense_t sense_next;

    function automatic logic [7:0] merge_write(input logic [7:0] cur, input logic bit_ok);
        logic [7:0] res;
        res = cur;
        if (sfr_wr_in) begin
            res = sfr_wdata_in;
        end else if (sfr_bit_wr_in && bit_ok) begin
            res[sfr_bit_idx_in] = sfr_bit_val_in;
        end
        return res;
    endfunction

    logic wr_any;
    assign wr_any = sfr_wr_in | sfr_bit_wr_in;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            port0_latch_reg <= pxg_pkg::RST_PORT0_DATA;
        end else if (wr_any && sfr_addr_in == pxg_pkg::ADDR_PORT0_DATA) begin
            port0_latch_reg <= merge_write(port0_latch_reg, 1'b1);
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            port1_latch_reg <= pxg_pkg::RST_PORT1_DATA;
        end else if (wr_any && sfr_addr_in == pxg_pkg::ADDR_PORT1_DATA) begin
            port1_latch_reg <= merge_write(port1_latch_reg, 1'b1);
        end
    end

    // Port 2 keeps bit 0 only
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            port2_latch_reg <= pxg_pkg::RST_PORT2_DATA;
        end else if (wr_any && sfr_addr_in == pxg_pkg::ADDR_PORT2_DATA) begin
            port2_latch_reg <= sfr_wr_in ? sfr_wdata_in[0]
                : (sfr_bit_idx_in == 3'h0) ? sfr_bit_val_in : port2_latch_reg;
        end
    end

    // Output drive selection
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            port0_drive_reg <= pxg_pkg::RST_OUTPUT_DRIVE;
            port1_drive_reg <= pxg_pkg::RST_OUTPUT_DRIVE;
            port2_drive_reg <= pxg_pkg::RST_PORT2_OUTPUT_DRIVE;
        end else if (sfr_wr_in) begin
            if (sfr_addr_in == pxg_pkg::ADDR_PORT0_OUTPUT_DRIVE) begin
                port0_drive_reg <= sfr_wdata_in;
            end
            if (sfr_addr_in == pxg_pkg::ADDR_PORT1_OUTPUT_DRIVE) begin
                port1_drive_reg <= sfr_wdata_in;
            end
            if (sfr_addr_in == pxg_pkg::ADDR_PORT2_OUTPUT_DRIVE) begin
                port2_drive_reg <= sfr_wdata_in[0];
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            port0_bypass_reg <= pxg_pkg::RST_CROSSBAR_BYPASS;
            port1_bypass_reg <= pxg_pkg::RST_CROSSBAR_BYPASS;
        end else if (sfr_wr_in) begin
            if (sfr_addr_in == pxg_pkg::ADDR_PORT0_CROSSBAR_BYPASS) begin
                port0_bypass_reg <= sfr_wdata_in;
            end
            if (sfr_addr_in == pxg_pkg::ADDR_PORT1_CROSSBAR_BYPASS) begin
                port1_bypass_reg <= sfr_wdata_in;
            end
        end
    end

    // Input kind, 1 digital, 0 analog
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            port0_kind_reg <= pxg_pkg::RST_INPUT_KIND;
            port1_kind_reg <= pxg_pkg::RST_INPUT_KIND;
        end else if (sfr_wr_in) begin
            if (sfr_addr_in == pxg_pkg::ADDR_PORT0_INPUT_KIND) begin
                port0_kind_reg <= sfr_wdata_in;
            end
            if (sfr_addr_in == pxg_pkg::ADDR_PORT1_INPUT_KIND) begin
                port1_kind_reg <= sfr_wdata_in;
            end
        end
    end

    // Crossbar control, bit 2 unused and reads zero
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            xbar_reg <= pxg_pkg::RST_CROSSBAR_CONTROL_B;
        end else if (sfr_wr_in && sfr_addr_in == pxg_pkg::ADDR_CROSSBAR_CONTROL_B) begin
            xbar_reg <= sfr_wdata_in & ~(8'h01 << 2);
        end
    end

    assign latch_all = {port2_latch_reg, port1_latch_reg, port0_latch_reg};
    assign drive_all = {port2_drive_reg, port1_drive_reg, port0_drive_reg};
    assign bypass_all = {1'b0, port1_bypass_reg, port0_bypass_reg};
    assign digital_all = {1'b1, port1_kind_reg, port0_kind_reg};

    // Which crossbar signals are requested
    always_comb begin
        sig_enable = 8'h00;
        sig_enable[pxg_pkg::SIG_SDA] = smbus_route_in;
        sig_enable[pxg_pkg::SIG_SCL] = smbus_route_in;
        sig_enable[pxg_pkg::SIG_CAPTURE0] = xbar_reg.capture_output_route != pxg_pkg::CAP_NONE;
        sig_enable[pxg_pkg::SIG_CAPTURE1] = xbar_reg.capture_output_route != pxg_pkg::CAP_NONE
            && xbar_reg.capture_output_route != pxg_pkg::CAP_0;
        sig_enable[pxg_pkg::SIG_CAPTURE2] = xbar_reg.capture_output_route != pxg_pkg::CAP_NONE
            && xbar_reg.capture_output_route != pxg_pkg::CAP_0
            && xbar_reg.capture_output_route != pxg_pkg::CAP_01;
        // Timer and counter clock input routes
        sig_enable[pxg_pkg::SIG_COUNTER_CLOCK] = xbar_reg.counter_clock_input_route;
        sig_enable[pxg_pkg::SIG_T0] = xbar_reg.timer0_input_route;
        sig_enable[pxg_pkg::SIG_T1] = xbar_reg.timer1_input_route;
        // Nothing routed while crossbar is off
        if (!xbar_reg.crossbar_enable) begin
            sig_enable = 8'h00;
        end
    end

    // Levels peripherals want on their pins; inputs idle high
    always_comb begin
        sig_value = 8'hFF;
        sig_is_input = 8'h00;
        sig_value[pxg_pkg::SIG_SDA] = periph_drive_in.sda;
        sig_value[pxg_pkg::SIG_SCL] = periph_drive_in.scl;
        sig_value[pxg_pkg::SIG_CAPTURE0] = periph_drive_in.capture_out[0];
        sig_value[pxg_pkg::SIG_CAPTURE1] = periph_drive_in.capture_out[1];
        sig_value[pxg_pkg::SIG_CAPTURE2] = periph_drive_in.capture_out[2];
        sig_is_input[pxg_pkg::SIG_COUNTER_CLOCK] = 1'b1;
        sig_is_input[pxg_pkg::SIG_T0] = 1'b1;
        sig_is_input[pxg_pkg::SIG_T1] = 1'b1;
    end

    // Priority assignment to lowest free pins
    always_comb begin
        int next_pin;
        logic found;
        next_pin = 0;
        found = 1'b0;
        claimed = '0;
        sig_pin_valid = 8'h00;
        for (int p = 0; p < pxg_pkg::NUM_PINS; p++) begin
            claim_sig[p] = 3'h0;
        end
        for (int s = 0; s < pxg_pkg::NUM_SIGS; s++) begin
            sig_pin[s] = 5'h00;
            found = 1'b0;
            if (sig_enable[s]) begin
                for (int p = 0; p < pxg_pkg::NUM_PINS; p++) begin
                    if (!found && p >= next_pin && !bypass_all[p]) begin
                        found = 1'b1;
                        claimed[p] = 1'b1;
                        claim_sig[p] = s[2:0];
                        sig_pin[s] = p[4:0];
                        sig_pin_valid[s] = 1'b1;
                        next_pin = p + 1;
                    end
                end
            end
        end
    end

    // Per pin driver, enable and pull-up
    generate
        for (genvar p = 0; p < pxg_pkg::NUM_PINS; p++) begin : g_pin
            logic value;
            logic forced_od;
            logic push_pull;
            logic drive_ok;
            assign value = claimed[p] ? sig_value[claim_sig[p]] : latch_all[p];
            assign forced_od = claimed[p] && (claim_sig[p] == 3'(pxg_pkg::SIG_SDA)
                || claim_sig[p] == 3'(pxg_pkg::SIG_SCL));
            // Drive bit ignored on analog pins
            assign push_pull = digital_all[p] && drive_all[p] && !forced_od;
            // Drivers off while crossbar is off
            assign drive_ok = xbar_reg.crossbar_enable && digital_all[p]
                && !(claimed[p] && sig_is_input[claim_sig[p]]);
            // Low driven whenever drive_ok, high only push-pull
            assign pin_out_next[p] = value;
            assign pin_oe_next[p] = drive_ok && (!value || push_pull);
            // Weak pull-up on open-drain not driving low
            assign pin_pullup_next[p] = !xbar_reg.pullup_disable && digital_all[p]
                && !push_pull && !pin_oe_next[p];
        end
    endgenerate

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pin_out <= '1;
            pin_oe_out <= '0;
            pin_pullup_out <= '0;
            pin_analog_out <= '0;
        end else begin
            pin_out <= pin_out_next;
            pin_oe_out <= pin_oe_next;
            pin_pullup_out <= pin_pullup_next;
            // Analog pins lose receiver and driver
            pin_analog_out <= ~digital_all;
        end
    end

    // Pin levels back to peripherals, idle high when unrouted
    always_comb begin
        sense_next = '1;
        if (sig_pin_valid[pxg_pkg::SIG_SDA]) begin
            sense_next.sda = pin_in[sig_pin[pxg_pkg::SIG_SDA]];
        end
        if (sig_pin_valid[pxg_pkg::SIG_SCL]) begin
            sense_next.scl = pin_in[sig_pin[pxg_pkg::SIG_SCL]];
        end
        if (sig_pin_valid[pxg_pkg::SIG_COUNTER_CLOCK]) begin
            sense_next.counter_array_clock_input = pin_in[sig_pin[pxg_pkg::SIG_COUNTER_CLOCK]];
        end
        if (sig_pin_valid[pxg_pkg::SIG_T0]) begin
            sense_next.timer0_input = pin_in[sig_pin[pxg_pkg::SIG_T0]];
        end
        if (sig_pin_valid[pxg_pkg::SIG_T1]) begin
            sense_next.timer1_input = pin_in[sig_pin[pxg_pkg::SIG_T1]];
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            periph_sense_out <= '1;
        end else begin
            periph_sense_out <= sense_next;
        end
    end

    // Register read mux
    always_comb begin
        rdata_next = 8'h00;
        case (sfr_addr_in)
            pxg_pkg::ADDR_PORT0_DATA: begin
                rdata_next = sfr_rmw_in ? port0_latch_reg : (pin_in[7:0] & port0_kind_reg);
            end
            pxg_pkg::ADDR_PORT1_DATA: begin
                rdata_next = sfr_rmw_in ? port1_latch_reg : (pin_in[15:8] & port1_kind_reg);
            end
            pxg_pkg::ADDR_PORT2_DATA: begin
                // Upper bits zero, bit 0 the pin, or the latch on a modify read
                rdata_next = {7'h00, sfr_rmw_in ? port2_latch_reg : pin_in[16]};
            end
            pxg_pkg::ADDR_PORT0_OUTPUT_DRIVE: begin
                rdata_next = port0_drive_reg;
            end
            pxg_pkg::ADDR_PORT1_OUTPUT_DRIVE: begin
                rdata_next = port1_drive_reg;
            end
            pxg_pkg::ADDR_PORT2_OUTPUT_DRIVE: begin
                rdata_next = {7'h00, port2_drive_reg};
            end
            pxg_pkg::ADDR_PORT0_CROSSBAR_BYPASS: begin
                rdata_next = port0_bypass_reg;
            end
            pxg_pkg::ADDR_PORT1_CROSSBAR_BYPASS: begin
                rdata_next = port1_bypass_reg;
            end
            pxg_pkg::ADDR_CROSSBAR_CONTROL_B: begin
                rdata_next = xbar_reg;
            end
            pxg_pkg::ADDR_PORT0_INPUT_KIND: begin
                rdata_next = port0_kind_reg;
            end
            pxg_pkg::ADDR_PORT1_INPUT_KIND: begin
                rdata_next = port1_kind_reg;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_rd_in) begin
            sfr_rdata_out <= rdata_next;
        end
    end

endmodule

// File: dv/pxg_port_io_properties.sv
/*
 Checker for the port crossbar block: concurrent properties on the top ports.
 Assumes one register access per cycle; mirrors a few registers from the strobes.
*/
`timescale 1ns/100ps
module pxg_port_io_properties (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Register access
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_bit_wr_in,
    input wire logic [2:0] sfr_bit_idx_in,
    input wire logic sfr_bit_val_in,
    input wire logic sfr_rd_in,
    input wire logic sfr_rmw_in,
    input wire logic [7:0] sfr_rdata_out,
    // Pins
    input wire logic [16:0] pin_in,
    input wire logic [16:0] pin_oe_out,
    input wire logic [16:0] pin_pullup_out,
    input wire logic [16:0] pin_analog_out
);
    logic [7:0] ctrl_reg;
    logic [15:0] kind_reg;
    logic [7:0] lat0_reg;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg <= 8'h00;
            kind_reg <= 16'hffff;
        end else if (sfr_wr_in) begin
            if (sfr_addr_in == 8'he2) ctrl_reg <= sfr_wdata_in;
            if (sfr_addr_in == 8'hf1) kind_reg[7:0] <= sfr_wdata_in;
            if (sfr_addr_in == 8'hf2) kind_reg[15:8] <= sfr_wdata_in;
        end
    end

    // Byte write wins over bit write
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            lat0_reg <= 8'hff;
        end else if (sfr_addr_in == 8'h80 && sfr_wr_in) begin
            lat0_reg <= sfr_wdata_in;
        end else if (sfr_addr_in == 8'h80 && sfr_bit_wr_in) begin
            lat0_reg[sfr_bit_idx_in] <= sfr_bit_val_in;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence rd0_s;
        sfr_rd_in && sfr_addr_in == 8'h80;
    endsequence
    sequence rd2_s;
        sfr_rd_in && (sfr_addr_in == 8'ha0 || sfr_addr_in == 8'ha6);
    endsequence

    xbar_off_quiet_a: assert property (
        !ctrl_reg[6] |=> pin_oe_out == 17'h0_0000) else $error("driver on with crossbar off");
    pullup_disabled_a: assert property (
        ctrl_reg[7] |=> pin_pullup_out == 17'h0_0000) else $error("pull-up while disabled");
    pullup_not_driving_a: assert property (
        (pin_pullup_out & pin_oe_out) == 17'h0_0000) else $error("pull-up on a driven pin");
    analog_follows_kind_a: assert property (
        pin_analog_out == {1'b0, ~$past(kind_reg)}) else $error("analog select mismatch");
    analog_silent_a: assert property (
        (pin_analog_out & (pin_oe_out | pin_pullup_out)) == 17'h0_0000)
        else $error("analog pin driven or pulled up");
    port_read_pins_a: assert property (
        rd0_s and !sfr_rmw_in |=> sfr_rdata_out == ($past(pin_in[7:0]) & $past(kind_reg[7:0])))
        else $error("port read not pin level");
    rmw_reads_latch_a: assert property (
        rd0_s and sfr_rmw_in |=> sfr_rdata_out == $past(lat0_reg))
        else $error("modify read not latch");
    port2_upper_zero_a: assert property (
        rd2_s |=> sfr_rdata_out[7:1] == 7'h00) else $error("unused bits not zero");
endmodule

// File: dv/pxg_pin_model.sv
/*
 Board around the pads: external drivers, pull-ups and floating lines.
 Assumes pad outputs come registered from the design.
*/
`timescale 1ns/100ps
module pxg_pin_model (
    // Clock
    input wire logic clk_sys_in,
    // Design pad outputs
    input wire logic [16:0] pad_val_in,
    input wire logic [16:0] pad_oe_in,
    input wire logic [16:0] pad_pullup_in,
    // Board drivers
    input wire logic [16:0] ext_en_in,
    input wire logic [16:0] ext_val_in,
    // Resolved pin levels
    output logic [16:0] pin_lvl_out
);
    logic [16:0] float_reg = 17'h0_0000;

    // Undriven lines without pull-up wander every cycle
    always_ff @(posedge clk_sys_in) begin
        float_reg <= ~pin_lvl_out;
    end
    assign pin_lvl_out = (pad_oe_in & pad_val_in) | (~pad_oe_in & ext_en_in & ext_val_in)
        | (~pad_oe_in & ~ext_en_in & (pad_pullup_in | float_reg));
endmodule

// File: dv/tb.sv
/*
 Self-checking bench for the port crossbar block.
 Assumes the pin model closes the pad loop and the checker is bound below.
*/
`timescale 1ns/100ps
module tb;
    logic clk_sys_in, rst_in, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, sfr_rmw, smbus_route;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [2:0] sfr_bit_idx;
    pxg_pkg::pxg_periph_drive_t pdrv;
    pxg_pkg::pxg_periph_sense_t sense;
    logic [16:0] pin_lvl, pout, poe, ppu, pan, ext_en, ext_val;
    logic [7:0] rf [logic [7:0]];
    int fail_count = 0;
    int total_checks = 0;
    int seed = 32'h9a5e;
    logic [31:0] r, q, s;

    pxg_port_io u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr),
        .sfr_wr_in(sfr_wr), .sfr_wdata_in(sfr_wdata), .sfr_bit_wr_in(sfr_bit_wr),
        .sfr_bit_idx_in(sfr_bit_idx), .sfr_bit_val_in(sfr_bit_val), .sfr_rd_in(sfr_rd),
        .sfr_rmw_in(sfr_rmw), .sfr_rdata_out(sfr_rdata), .smbus_route_in(smbus_route),
        .periph_drive_in(pdrv), .periph_sense_out(sense), .pin_in(pin_lvl), .pin_out(pout),
        .pin_oe_out(poe), .pin_pullup_out(ppu), .pin_analog_out(pan));
    pxg_pin_model u_pins (.clk_sys_in(clk_sys_in), .pad_val_in(pout), .pad_oe_in(poe),
        .pad_pullup_in(ppu), .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_lvl_out(pin_lvl));

    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Strobes k: write, bit write, read, modify read
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic [3:0] k);
        {sfr_wr, sfr_bit_wr, sfr_rd, sfr_rmw} <= k;
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_bit_idx <= d[2:0];
        sfr_bit_val <= d[3];
        @(negedge clk_sys_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, d, 4'h8);
        if (rf.exists(a)) rf[a] = d & ((a == 8'ha0 || a == 8'ha6) ? 8'h01
            : (a == 8'he2) ? 8'hfb : 8'hff);
    endtask

    task automatic bw(input logic [7:0] a, input logic [2:0] i, input logic v);
        acc(a, {4'h0, v, i}, 4'h4);
        if (a != 8'ha0 || i == 3'h0) rf[a][i] = v;
    endtask

    task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e,
                      input logic [7:0] k);
        acc(a, 8'h00, {3'h1, m});
        chk(17'(sfr_rdata & k), 17'(e & k));
    endtask

    task automatic pads();
        logic [16:0] lat, drv, dig, eo, eoe, epu, lvl, kn;
        logic [15:0] byp;
        logic [7:0] ctl, en;
        logic [4:0] es, sk;
        int asg [17] = '{default: 8};
        int p, b;
        logic pp, v;
        lat = {rf[8'ha0][0], rf[8'h90], rf[8'h80]};
        drv = {rf[8'ha6][0], rf[8'ha5], rf[8'ha4]};
        dig = {1'b1, rf[8'hf2], rf[8'hf1]};
        byp = {rf[8'hd5], rf[8'hd4]};
        ctl = rf[8'he2];
        en = {ctl[5:3], ctl[1:0] == 2'h3, ctl[1], ctl[1:0] != 2'h0, smbus_route, smbus_route};
        p = 0;
        es = 5'h1f;
        sk = 5'h1f;
        for (int g = 0; g < 8; g++) begin
            if (ctl[6] && en[g] && p < 17) begin
                while (p < 16 && byp[p]) p++;
                asg[p] = g;
                p++;
            end
        end
        for (int i = 0; i < 17; i++) begin
            pp = drv[i] && asg[i] > 1;
            v = asg[i] < 2 ? pdrv[4 - asg[i]] : asg[i] < 5 ? pdrv[asg[i] - 2] : lat[i];
            eo[i] = v;
            eoe[i] = ctl[6] && dig[i] && (asg[i] < 5 || asg[i] == 8) && (!v || pp);
            epu[i] = !ctl[7] && dig[i] && !pp && !eoe[i];
            lvl[i] = eoe[i] ? v : ext_en[i] ? ext_val[i] : 1'b1;
            kn[i] = eoe[i] || ext_en[i] || epu[i];
            if (asg[i] < 2 || (asg[i] > 4 && asg[i] < 8)) begin
                b = asg[i] < 2 ? 4 - asg[i] : 7 - asg[i];
                es[b] = lvl[i];
                sk[b] = kn[i];
            end
        end
        chk(poe, eoe);
        chk(poe & pout, eoe & eo);
        chk(ppu, epu);
        chk(pan, ~dig);
        chk(17'(sense & sk), 17'(es & sk));
        rd(8'h80, 1'b0, lvl[7:0] & dig[7:0], kn[7:0] | ~dig[7:0]);
        rd(8'h90, 1'b0, lvl[15:8] & dig[15:8], kn[15:8] | ~dig[15:8]);
        rd(8'ha0, 1'b0, {7'h00, lvl[16]}, {7'h7f, kn[16]});
        foreach (rf[a]) rd(a, a == 8'h80 || a == 8'h90 || a == 8'ha0, rf[a], 8'hff);
        rd(8'hb0, 1'b0, 8'h00, 8'hff);
    endtask

    initial begin
        rst_in = 1'b1;
        {sfr_wr, sfr_bit_wr, sfr_rd, sfr_rmw, sfr_bit_val, smbus_route} = 6'h00;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_bit_idx = 3'h0;
        pdrv = 5'h00;
        ext_en = 17'h0_0000;
        ext_val = 17'h0_0000;
        rf = '{8'h80: 8'hff, 8'h90: 8'hff, 8'ha0: 8'h01, 8'ha4: 8'h00, 8'ha5: 8'h00,
            8'ha6: 8'h00, 8'hd4: 8'h00, 8'hd5: 8'h00, 8'he2: 8'h00, 8'hf1: 8'hff, 8'hf2: 8'hff};
        repeat (4) @(negedge clk_sys_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        pads();
        for (int n = 0; n < 60; n++) begin
            r = $random(seed);
            q = $random(seed);
            s = $random(seed);
            wr(8'hf1, r[7:0]);
            wr(8'hf2, r[15:8]);
            wr(8'hd4, r[23:16] | ~r[7:0]);
            wr(8'hd5, r[31:24] | ~r[15:8]);
            wr(8'ha4, q[7:0]);
            wr(8'ha5, q[15:8]);
            wr(8'ha6, q[23:16]);
            wr(8'he2, q[31:24] | {1'b0, n[0], 6'h00});
            wr(8'h80, s[7:0]);
            wr(8'h90, s[15:8]);
            wr(8'ha0, s[23:16]);
            bw(8'h90, s[26:24], s[27]);
            bw(8'ha0, s[30:28], s[31]);
            s = $random(seed);
            ext_en <= s[16:0];
            ext_val <= s[31:15];
            smbus_route <= s[13];
            pdrv <= s[12:8];
            acc(8'h00, 8'h00, 4'h0);
            repeat (3) @(negedge clk_sys_in);
            pads();
        end
        tally_and_finish();
    end

    initial begin
        #400_000;
        fail_count++;
        tally_and_finish();
    end
endmodule

bind pxg_port_io pxg_port_io_properties u_props (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_bit_wr_in(sfr_bit_wr_in), .sfr_bit_idx_in(sfr_bit_idx_in),
    .sfr_bit_val_in(sfr_bit_val_in), .sfr_rd_in(sfr_rd_in), .sfr_rmw_in(sfr_rmw_in),
    .sfr_rdata_out(sfr_rdata_out), .pin_in(pin_in), .pin_oe_out(pin_oe_out),
    .pin_pullup_out(pin_pullup_out), .pin_analog_out(pin_analog_out));
